// *** hdl/angle_wave_unit.sv ***
// electrical angle timer, sine table and waveform arithmetic with a plain register port
// assumes synchronous register strobes, a position detect pulse and one 100 MHz clock
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

//Contract
//(RULE_01) sixteen-step group uses m+1 n times
//(RULE_02) step period below 010H acts as 010H
//(RULE_03) cycle lasts (m+n/16)*384 count clocks
//(RULE_04) angle readable, writes above 17FH ignored
//(RULE_05) scale times sample, limited by pwm period
//(RULE_06) position detect captures current angle
//(RULE_07) software loads table 000H..17FH, calc off
//(RULE_08) trigger bit one starts calc, zero nothing
//(RULE_09) busy bit shows calculation in progress
//(RULE_10) select angle-synced or software-only calc start
//(RULE_11) interrupt source: timer finish or calc end
//(RULE_12) no read-modify-write on second control register
//(RULE_13) direction bit: zero up, one down
//(RULE_14) phase order bit: plus or minus 120/240
//(RULE_15) clock select fc/8, /16, /32, /64
//(RULE_16) software changes clock only with timer off
//(RULE_17) modulation bit: two-phase or three-phase
//(RULE_18) transfer bit copies results to pwm compare
//(RULE_19) three-phase sign flips at 180 degrees
//(RULE_20) sample register written with plain writes only
//(RULE_21) soft start during calc restarts it
//(RULE_22) timer enable runs, disable stops and clears
//(RULE_23) three-phase: half period plus/minus half term
//(RULE_24) calc enable runs arithmetic, results readable
//(RULE_25) angle steps each period, wraps over 384
module angle_wave_unit
    import angle_wave_pkg::*;
#(
    parameter int SAMPLE_W = 8,
    parameter int SCALE_W  = 8
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire reg_req_t    req,
    input  wire logic        pos_detect,
    output logic [15:0]      rdata,
    output duty_t            duty,
    output logic             angle_irq
);

    typedef struct packed {
        logic [7:0]          ctrl_a;
        logic                synced;
        logic                irq_sel;
        logic [15:0]         period;
        logic [8:0]          angle;
        logic [SCALE_W-1:0]  scale;
        logic [15:0]         pwm_per;
        logic [8:0]          capture;
        logic [15:0]         cmp_u;
        logic [15:0]         cmp_v;
        logic [15:0]         cmp_w;
        duty_t               duty;
        logic                irq;
        logic [5:0]          presc;
        logic [12:0]         step_cnt;
        logic [3:0]          group;
        calc_state_t         st;
        logic [15:0]         rdata;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    logic [SAMPLE_W-1:0] sine_ram [384];

    logic [11:0]          m_eff;
    logic [12:0]          per_now;
    logic [5:0]           div_last;
    logic                 tick;
    logic                 step;
    logic [8:0]           next_ang;
    logic                 ang_wr_ok;
    logic                 tmr_stop;
    logic                 soft_go;
    logic                 sync_go;
    logic [9:0]           ph_off;
    logic [9:0]           idx_sum;
    logic [8:0]           idx;
    logic [SAMPLE_W-1:0]  samp;
    logic [15:0]          prod;
    logic [15:0]          limited;
    logic [15:0]          result;

    // period with floor, correction and count-clock prescale
    always_comb begin
        m_eff    = (state_ff.period[PER_HI:0] < PERIOD_MIN) ? PERIOD_MIN
                 : state_ff.period[PER_HI:0];                                 // RULE_02
        per_now  = (state_ff.group < state_ff.period[CORR_HI:CORR_LO])
                 ? {1'b0, m_eff} + 13'h0001 : {1'b0, m_eff};                  // RULE_01
        div_last = 6'(({1'b0, PRESC_BASE} << state_ff.ctrl_a[CLK_SEL_HI:CLK_SEL_LO])
                 - 7'h01);                                                    // RULE_15
        tick     = state_ff.ctrl_a[TMR_EN_BIT] && (state_ff.presc == div_last);
        // >= so a period shrunk mid-step cannot strand the counter
        step     = tick && (state_ff.step_cnt >= per_now - 13'h0001);         // RULE_03
    end

    // next angle in the selected direction, wrapping over 384 steps
    always_comb begin
        if (state_ff.ctrl_a[DIR_BIT]) begin                                   // RULE_13
            next_ang = (state_ff.angle == 9'h000) ? ANGLE_MAX
                     : state_ff.angle - 9'h001;
        end else begin
            next_ang = (state_ff.angle >= ANGLE_MAX) ? 9'h000
                     : state_ff.angle + 9'h001;                               // RULE_25
        end
    end

    // write qualifiers and calculation start causes
    always_comb begin
        ang_wr_ok = req.wr && (req.addr == ANGLE_ADDR)
                  && (req.wdata[15:0] <= {7'h00, ANGLE_MAX});                 // RULE_04
        soft_go   = req.wr && (req.addr == CTRL_B_ADDR) && req.wdata[TRIG_BIT]; // RULE_08
        tmr_stop  = req.wr && (req.addr == CTRL_A_ADDR) && !req.wdata[TMR_EN_BIT]
                  && state_ff.ctrl_a[TMR_EN_BIT];                             // RULE_22
        sync_go   = state_ff.synced && (step || ang_wr_ok);                   // RULE_10
    end

    // table index of the phase being worked on
    always_comb begin
        case (state_ff.st)
            CALC_V:  ph_off = state_ff.ctrl_a[ORDER_BIT] ? PHASE_240 : PHASE_120; // RULE_14
            CALC_W:  ph_off = state_ff.ctrl_a[ORDER_BIT] ? PHASE_120 : PHASE_240;
            default: ph_off = 10'd0;
        endcase
        idx_sum = {1'b0, state_ff.angle} + ph_off;
        idx     = (idx_sum >= ANGLE_STEPS) ? 9'(idx_sum - ANGLE_STEPS) : idx_sum[8:0];
        samp    = sine_ram[idx];
    end

    // scaled sample, limit and modulation
    always_comb begin
        prod    = 16'(samp * state_ff.scale);                                 // RULE_05
        limited = (prod > state_ff.pwm_per) ? state_ff.pwm_per : prod;
        if (!state_ff.ctrl_a[MOD_BIT]) begin                                  // RULE_17
            result = limited;
        end else if (idx < HALF_TURN) begin                                   // RULE_19
            result = (state_ff.pwm_per >> 1) + (limited >> 1);                // RULE_23
        end else begin
            result = (state_ff.pwm_per >> 1) - (limited >> 1);                // RULE_23
        end
    end

    // next state of the whole unit
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.irq       = 1'b0;
        nxt_state.duty.load = 1'b0;
        nxt_state.rdata     = 16'h0000;
        // timer counting
        if (!state_ff.ctrl_a[TMR_EN_BIT]) begin                               // RULE_22
            nxt_state.presc    = 6'h00;
            nxt_state.step_cnt = 13'h0000;
            nxt_state.group    = 4'h0;
        end else begin
            nxt_state.presc = tick ? 6'h00 : state_ff.presc + 6'h01;
            if (tick) begin
                nxt_state.step_cnt = step ? 13'h0000 : state_ff.step_cnt + 13'h0001;
            end
            if (step) begin
                nxt_state.angle = next_ang;                                   // RULE_25
                nxt_state.group = state_ff.group + 4'h1;                      // RULE_01
                nxt_state.irq   = !state_ff.irq_sel;                          // RULE_11
            end
        end
        // disable clears the angle once; it then holds for table loading
        if (tmr_stop) begin
            nxt_state.angle = 9'h000;                                         // RULE_22
        end
        if (pos_detect) begin
            nxt_state.capture = state_ff.angle;                               // RULE_06
        end
        // waveform calculation sequence
        case (state_ff.st)
            CALC_U: begin
                nxt_state.cmp_u = result;
                nxt_state.st    = CALC_V;
            end
            CALC_V: begin
                nxt_state.cmp_v = result;
                nxt_state.st    = CALC_W;
            end
            CALC_W: begin
                nxt_state.cmp_w = result;
                nxt_state.st    = CALC_IDLE;
                nxt_state.irq   = nxt_state.irq | state_ff.irq_sel;           // RULE_11
                if (state_ff.ctrl_a[XFER_BIT]) begin                          // RULE_18
                    nxt_state.duty.u    = state_ff.cmp_u;
                    nxt_state.duty.v    = state_ff.cmp_v;
                    nxt_state.duty.w    = result;
                    nxt_state.duty.load = 1'b1;
                end
            end
            default: nxt_state.st = CALC_IDLE;
        endcase
        if (state_ff.ctrl_a[CALC_EN_BIT] && (soft_go || sync_go)) begin       // RULE_24
            nxt_state.st = CALC_U;                                            // RULE_21
        end
        if (!state_ff.ctrl_a[CALC_EN_BIT]) begin
            nxt_state.st = CALC_IDLE;
        end
        // register writes
        if (req.wr) begin
            if (req.addr == CTRL_A_ADDR) begin
                nxt_state.ctrl_a = req.wdata[7:0];
            end else if (req.addr == CTRL_B_ADDR) begin
                nxt_state.synced  = req.wdata[SYNC_BIT];
                nxt_state.irq_sel = req.wdata[IRQ_SEL_BIT];
            end else if (req.addr == PERIOD_ADDR) begin
                nxt_state.period = req.wdata;
            end else if (ang_wr_ok) begin
                nxt_state.angle = req.wdata[8:0];                             // RULE_04
            end else if (req.addr == SCALE_ADDR) begin
                nxt_state.scale = req.wdata[SCALE_W-1:0];
            end else if (req.addr == PWM_PER_ADDR) begin
                nxt_state.pwm_per = req.wdata;
            end
        end
        // register reads, data valid in the next cycle
        if (req.rd) begin
            if (req.addr == CTRL_A_ADDR) begin
                nxt_state.rdata = {8'h00, state_ff.ctrl_a};
            end else if (req.addr == CTRL_B_ADDR) begin
                nxt_state.rdata = {13'h0000, state_ff.st != CALC_IDLE,
                                   state_ff.synced, state_ff.irq_sel};        // RULE_09
            end else if (req.addr == PERIOD_ADDR) begin
                nxt_state.rdata = state_ff.period;
            end else if (req.addr == ANGLE_ADDR) begin
                nxt_state.rdata = {7'h00, state_ff.angle};                    // RULE_04
            end else if (req.addr == SCALE_ADDR) begin
                nxt_state.rdata = 16'(state_ff.scale);
            end else if (req.addr == PWM_PER_ADDR) begin
                nxt_state.rdata = state_ff.pwm_per;
            end else if (req.addr == CAPTURE_ADDR) begin
                nxt_state.rdata = {7'h00, state_ff.capture};
            end else if (req.addr == CMP_U_ADDR) begin
                nxt_state.rdata = state_ff.cmp_u;                             // RULE_24
            end else if (req.addr == CMP_V_ADDR) begin
                nxt_state.rdata = state_ff.cmp_v;
            end else if (req.addr == CMP_W_ADDR) begin
                nxt_state.rdata = state_ff.cmp_w;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff         <= '0;
            state_ff.ctrl_a  <= CTRL_A_RST;
            state_ff.period  <= PERIOD_RST;
            state_ff.pwm_per <= PWM_PER_RST;
            state_ff.st      <= CALC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // sine table, written at the current angle
    always_ff @(posedge core_clk) begin
        if (req.wr && (req.addr == SAMPLE_ADDR)) begin
            sine_ram[state_ff.angle] <= req.wdata[SAMPLE_W-1:0];             // RULE_07
        end
    end

    assign rdata     = state_ff.rdata;
    assign duty      = state_ff.duty;
    assign angle_irq = state_ff.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence calc_go;
        soft_go && state_ff.ctrl_a[CALC_EN_BIT] && !(req.wr && req.addr == CTRL_A_ADDR);
    endsequence

    sequence calc_quiet;
        !soft_go && !sync_go && !(req.wr && req.addr == CTRL_A_ADDR);
    endsequence

    sequence calc_tail;
        $past(state_ff.st) == CALC_U && state_ff.st == CALC_V ##1 state_ff.st == CALC_W;
    endsequence

    angle_in_range_a: assert property (state_ff.angle <= ANGLE_MAX) // RULE_25
        else $error("angle left 0..17f");
    angle_write_a: assert property (ang_wr_ok |=> state_ff.angle == $past(req.wdata[8:0])) // RULE_04
        else $error("legal angle write lost");
    bad_write_a: assert property (req.wr && req.addr == ANGLE_ADDR && !ang_wr_ok && !step
        |=> state_ff.angle == $past(state_ff.angle)) // RULE_04
        else $error("illegal angle write took effect");
    timer_clear_a: assert property (tmr_stop |=> state_ff.angle == 9'h000) // RULE_22
        else $error("disabled timer not cleared");
    busy_read_a: assert property (req.rd && req.addr == CTRL_B_ADDR
        |=> rdata[BUSY_BIT] == ($past(state_ff.st) != CALC_IDLE)) // RULE_09
        else $error("busy bit wrong");
    soft_start_a: assert property (calc_go ##1 calc_quiet [*2] |-> calc_tail) // RULE_21
        else $error("soft start did not run U V W");
    capture_a: assert property (pos_detect |=> state_ff.capture == $past(state_ff.angle)) // RULE_06
        else $error("capture missed angle");
    period_floor_a: assert property (step
        |-> state_ff.step_cnt >= {1'b0, PERIOD_MIN} - 13'h0001) // RULE_02
        else $error("period below floor");
    count_up_a: assert property (step && !state_ff.ctrl_a[DIR_BIT] && !ang_wr_ok && !tmr_stop
        |=> state_ff.angle == (($past(state_ff.angle) == ANGLE_MAX) ? 9'h000
                               : $past(state_ff.angle) + 9'h001)) // RULE_13
        else $error("up count step wrong");
    timer_irq_a: assert property (step && !state_ff.irq_sel |=> angle_irq) // RULE_11
        else $error("timer interrupt missing");
    no_xfer_a: assert property (!state_ff.ctrl_a[XFER_BIT] |=> !duty.load) // RULE_18
        else $error("transfer while disabled");
    three_phase_a: assert property (state_ff.st != CALC_IDLE && state_ff.ctrl_a[MOD_BIT]
        && idx < HALF_TURN |-> result >= (state_ff.pwm_per >> 1)) // RULE_23
        else $error("three-phase sign wrong");
endmodule

// *** hdl/angle_wave_pkg.sv ***
// constants, register map and carrier types of the electrical angle / sine waveform unit
// assumes a 16-bit plain register port and one system clock
package angle_wave_pkg;

    // register offsets (word per address)
    localparam logic [12:0] CTRL_A_ADDR    = 13'h1fc0;
    localparam logic [12:0] CTRL_B_ADDR    = 13'h1fc1;
    localparam logic [12:0] PERIOD_ADDR    = 13'h1fc2;
    localparam logic [12:0] ANGLE_ADDR     = 13'h1fc4;
    localparam logic [12:0] SCALE_ADDR     = 13'h1fc5;
    localparam logic [12:0] PWM_PER_ADDR   = 13'h1fc6;
    localparam logic [12:0] CAPTURE_ADDR   = 13'h1fc7;
    localparam logic [12:0] SAMPLE_ADDR    = 13'h1fc8;
    localparam logic [12:0] CMP_U_ADDR     = 13'h1fc9;
    localparam logic [12:0] CMP_V_ADDR     = 13'h1fca;
    localparam logic [12:0] CMP_W_ADDR     = 13'h1fcb;

    // reset values
    localparam logic [7:0]  CTRL_A_RST     = 8'h00;
    localparam logic [15:0] PERIOD_RST     = 16'h0010;
    localparam logic [15:0] PWM_PER_RST    = 16'hffff;

    // control bit positions
    localparam int DIR_BIT     = 7;
    localparam int ORDER_BIT   = 6;
    localparam int CLK_SEL_HI  = 5;
    localparam int CLK_SEL_LO  = 4;
    localparam int MOD_BIT     = 3;
    localparam int XFER_BIT    = 2;
    localparam int CALC_EN_BIT = 1;
    localparam int TMR_EN_BIT  = 0;
    localparam int TRIG_BIT    = 3;
    localparam int BUSY_BIT    = 2;
    localparam int SYNC_BIT    = 1;
    localparam int IRQ_SEL_BIT = 0;

    // period field layout and angle limits
    localparam int          CORR_HI     = 15;
    localparam int          CORR_LO     = 12;
    localparam int          PER_HI      = 11;
    localparam logic [11:0] PERIOD_MIN  = 12'h010;
    localparam logic [8:0]  ANGLE_MAX   = 9'h17f;
    localparam logic [9:0]  ANGLE_STEPS = 10'd384;
    localparam logic [9:0]  PHASE_120   = 10'd128;
    localparam logic [9:0]  PHASE_240   = 10'd256;
    localparam logic [8:0]  HALF_TURN   = 9'd192;
    localparam logic [5:0]  PRESC_BASE  = 6'h08;

    typedef enum logic [1:0] {CALC_IDLE, CALC_U, CALC_V, CALC_W} calc_state_t;

    // register port request
    typedef struct packed {
        logic [12:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // duty values handed to the pwm compare registers
    typedef struct packed {
        logic [15:0] u;
        logic [15:0] v;
        logic [15:0] w;
        logic        load;
    } duty_t;
endpackage

// *** verif/pwm_side_model.sv ***
// far-side model: pwm compare registers and position detector
// assumes duty.load is a one-cycle pulse on core_clk
`timescale 1ns/100ps
module pwm_side_model
    import angle_wave_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   arst_n,
    input  wire duty_t  duty,
    input  wire logic   fire,
    output logic        pos_detect,
    output logic [15:0] cmp_u,
    output logic [15:0] cmp_v,
    output logic [15:0] cmp_w,
    output logic [7:0]  load_cnt
);
    // compare registers take each transferred set; loads are counted
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_detect <= 1'b0;
            cmp_u      <= 16'h0000;
            cmp_v      <= 16'h0000;
            cmp_w      <= 16'h0000;
            load_cnt   <= 8'h00;
        end else begin
            pos_detect <= fire;
            if (duty.load) begin
                cmp_u    <= duty.u;
                cmp_v    <= duty.v;
                cmp_w    <= duty.w;
                load_cnt <= load_cnt + 8'h01;
            end
        end
    end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the angle timer and waveform unit
// assumes the package and the pwm side model are compiled first
`timescale 1ns/100ps
module tb_top
    import angle_wave_pkg::*;
;
    logic        core_clk;
    logic        arst_n;
    reg_req_t    req;
    logic        fire;
    logic        pos_detect;
    logic [15:0] rdata;
    duty_t       duty;
    logic        angle_irq;
    logic [15:0] cmp_u;
    logic [15:0] cmp_v;
    logic [15:0] cmp_w;
    logic [7:0]  load_cnt;
    int          miscompares;
    int          num_checks;

    angle_wave_unit u_dut (.core_clk(core_clk), .arst_n(arst_n), .req(req),
        .pos_detect(pos_detect), .rdata(rdata), .duty(duty), .angle_irq(angle_irq));
    pwm_side_model u_far (.core_clk(core_clk), .arst_n(arst_n), .duty(duty), .fire(fire),
        .pos_detect(pos_detect), .cmp_u(cmp_u), .cmp_v(cmp_v), .cmp_w(cmp_w),
        .load_cnt(load_cnt));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one-cycle register port strobes
    task automatic reg_wr(input logic [12:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge core_clk);
        req.wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [12:0] a, output logic [15:0] d);
        @(posedge core_clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge core_clk);
        req.rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // counts edges until the n-th irq or load pulse
    task automatic wait_pulse(input bit use_load, input int n, output int cyc);
        int seen;
        seen = 0;
        cyc = 0;
        while (seen < n) begin
            @(posedge core_clk);
            #1;
            cyc++;
            if ((use_load ? duty.load : angle_irq) === 1'b1) seen++;
            if (cyc > 60000) begin
                miscompares++;
                $display("ERROR t=%0t pulse wait ran out", $time);
                print_verdict();
            end
        end
    endtask

    task automatic no_load(input string what);
        logic [7:0] ld;
        @(posedge core_clk);
        #1;
        ld = load_cnt;
        repeat (8) @(posedge core_clk);
        #1;
        check({8'h00, load_cnt - ld}, 16'h0000, what);
    endtask

    task automatic t_reset_regs();
        logic [15:0] v;
        reg_rd(CTRL_A_ADDR, v);
        check(v, 16'h0000, "ctrl_a reset");
        reg_rd(PERIOD_ADDR, v);
        check(v, 16'h0010, "period reset");
        reg_rd(CTRL_B_ADDR, v);
        check(v, 16'h0000, "ctrl_b reset");
        reg_rd(13'h1fd0, v);
        check(v, 16'h0000, "unmapped read");
        $display("test reset_regs done");
    endtask

    task automatic t_timer_rate();
        int          cyc;
        logic [15:0] v;
        for (int sel = 0; sel < 4; sel++) begin
            reg_wr(CTRL_A_ADDR, 16'(sel << 4));
            reg_wr(CTRL_A_ADDR, 16'(sel << 4) | 16'h0001);
            wait_pulse(1'b0, 1, cyc);
            check(16'(cyc), 16'(128 << sel), "step time");
            reg_rd(ANGLE_ADDR, v);
            check(v, 16'h0001, "angle after step");
            reg_wr(CTRL_A_ADDR, 16'h0000);
            reg_rd(ANGLE_ADDR, v);
            check(v, 16'h0000, "angle cleared");
        end
        $display("test timer_rate done");
    endtask

    task automatic t_timer_corr();
        int          cyc;
        logic [15:0] v;
        reg_wr(PERIOD_ADDR, 16'h4010);
        reg_wr(CTRL_A_ADDR, 16'h0001);
        wait_pulse(1'b0, 16, cyc);
        check(16'(cyc), 16'd2080, "corrected group");
        wait_pulse(1'b0, 368, cyc);
        check(16'(cyc), 16'd47840, "rest of turn");
        reg_rd(ANGLE_ADDR, v);
        check(v, 16'h0000, "angle wrap");
        reg_wr(CTRL_A_ADDR, 16'h0000);
        reg_wr(PERIOD_ADDR, 16'h0005);
        reg_wr(CTRL_A_ADDR, 16'h0080);
        reg_wr(CTRL_A_ADDR, 16'h0081);
        wait_pulse(1'b0, 1, cyc);
        check(16'(cyc), 16'd128, "short period");
        reg_rd(ANGLE_ADDR, v);
        check(v, 16'h017f, "count down");
        reg_wr(CTRL_A_ADDR, 16'h0000);
        reg_wr(PERIOD_ADDR, 16'h0010);
        $display("test timer_corr done");
    endtask

    task automatic t_angle_capture();
        logic [15:0] v;
        reg_wr(ANGLE_ADDR, 16'h017f);
        reg_wr(ANGLE_ADDR, 16'h0180);
        reg_rd(ANGLE_ADDR, v);
        check(v, 16'h017f, "angle over limit");
        reg_wr(ANGLE_ADDR, 16'h0055);
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (3) @(posedge core_clk);
        reg_rd(CAPTURE_ADDR, v);
        check(v, 16'h0055, "capture");
        $display("test angle_capture done");
    endtask

    task automatic t_calc_modes();
        int          cyc;
        logic [15:0] v;
        logic [15:0] cfg [3] = '{16'h0006, 16'h000e, 16'h004e};
        logic [15:0] eu [3]  = '{16'h00c0, 16'h00e0, 16'h00e0};
        logic [15:0] ev [3]  = '{16'h0060, 16'h00b0, 16'h0000};
        logic [15:0] ew [3]  = '{16'h0100, 16'h0000, 16'h00b0};
        // table loaded with arithmetic off, one sample at each of the three phase angles
        reg_wr(CTRL_A_ADDR, 16'h0000);
        reg_wr(ANGLE_ADDR, 16'h0010);
        reg_wr(SAMPLE_ADDR, 16'h0040);
        reg_wr(ANGLE_ADDR, 16'h0090);
        reg_wr(SAMPLE_ADDR, 16'h0020);
        reg_wr(ANGLE_ADDR, 16'h0110);
        reg_wr(SAMPLE_ADDR, 16'h0060);
        reg_wr(SCALE_ADDR, 16'h0003);
        reg_wr(PWM_PER_ADDR, 16'h0100);
        reg_wr(ANGLE_ADDR, 16'h0010);
        for (int i = 0; i < 3; i++) begin
            reg_wr(CTRL_A_ADDR, cfg[i]);
            reg_wr(CTRL_B_ADDR, 16'h0009);
            wait_pulse(1'b1, 1, cyc);
            check(16'(cyc), 16'd3, "calc latency");
            check({15'h0000, angle_irq}, 16'h0001, "calc end irq");
            check(duty.u, eu[i], "duty u");
            check(duty.v, ev[i], "duty v");
            check(duty.w, ew[i], "duty w");
            reg_rd(CMP_W_ADDR, v);
            check(v, ew[i], "result w");
            check(cmp_w, ew[i], "far compare w");
            check(cmp_u, eu[i], "far compare u");
            check(cmp_v, ev[i], "far compare v");
        end
        $display("test calc_modes done");
    endtask

    task automatic t_calc_control();
        int          cyc;
        logic [15:0] v;
        reg_wr(CTRL_A_ADDR, 16'h0006);
        reg_wr(CTRL_B_ADDR, 16'h0008);
        reg_rd(CTRL_B_ADDR, v);
        check(v & 16'h000c, 16'h0004, "busy high");
        repeat (4) @(posedge core_clk);
        reg_rd(CTRL_B_ADDR, v);
        check(v & 16'h000c, 16'h0000, "busy low");
        reg_wr(CTRL_B_ADDR, 16'h0008);
        reg_wr(CTRL_B_ADDR, 16'h0008);
        wait_pulse(1'b1, 1, cyc);
        check(16'(cyc), 16'd3, "restart latency");
        no_load("restart single load");
        reg_wr(CTRL_B_ADDR, 16'h0000);
        no_load("zero trigger");
        reg_wr(CTRL_A_ADDR, 16'h0004);
        reg_wr(CTRL_B_ADDR, 16'h0008);
        no_load("calc disabled");
        reg_wr(CTRL_A_ADDR, 16'h000a);
        reg_wr(CTRL_B_ADDR, 16'h0008);
        no_load("transfer off");
        reg_rd(CMP_U_ADDR, v);
        check(v, 16'h00e0, "result without transfer");
        reg_wr(CTRL_A_ADDR, 16'h0006);
        reg_wr(CTRL_B_ADDR, 16'h0002);
        reg_wr(ANGLE_ADDR, 16'h0010);
        wait_pulse(1'b1, 1, cyc);
        check(16'(cyc), 16'd3, "synced start");
        $display("test calc_control done");
    endtask

    // reset, then the scenarios in turn
    initial begin
        arst_n      = 1'b0;
        req         = '0;
        fire        = 1'b0;
        miscompares = 0;
        num_checks  = 0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset_regs();
        t_timer_rate();
        t_timer_corr();
        t_angle_capture();
        t_calc_modes();
        t_calc_control();
        print_verdict();
    end
endmodule
